// [design/dl_mem.sv]
// sample memory of the variable path delay line, registered read
`timescale 1ns/1ps
`default_nettype none
module dl_mem
  import pm_pkg::*;
(
  // clock
  input  wire logic i_ref_clk,
  // access
  dl_mem_if.mem     m
);
  logic [SMP_W-1:0] mem_q [DL_DEPTH];

  always_ff @(posedge i_ref_clk)
  begin
    if (m.we)
    begin
      mem_q[m.waddr] <= m.wdata;
    end
  end

  // read before write on a shared address
  always_ff @(posedge i_ref_clk)
  begin
    m.rdata <= mem_q[m.raddr];
  end
endmodule : dl_mem
`default_nettype wire

// [design/input_power_meter.sv]
// received power meter with APB registers, interrupt and path delay line
// Notes on behaviour
// R1 - each meter runs only while its enable bit is set
// R2 - each meter takes its sync from its own 3-bit source choice
// R3 - accumulation length counts eight samples or eight I/Q pairs per unit
// R4 - square and sum I only, or I and Q in complex mode
// R5 - window opens 8*delay+2 samples after sync, and at each period boundary
// R6 - at 8*length+1 samples publish the sum and raise an interrupt
// R7 - period timer counts 8*period+1 samples, restarting the sum each time
// R8 - software keeps the period longer than the window
// R9 - period counter and sum start together after the delay, restart at limit
// R10 - 9-bit start delay in eight-sample units plus two samples
// R11 - 6-bit offset sets the first path delay line pointer offset
// R12 - bits 20:16 of length and period sit in the config register
// R13 - 3-bit source choice says when the delay pointer offset updates
// R14 - complex select pairs the first and second inputs as I and Q
// R15 - result holds until the next window ends; one done event per window
`timescale 1ns/1ps
`default_nettype none
module input_power_meter
  import pm_pkg::*;
#(
  parameter int ACC_W = 56
)(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output var  logic [31:0]       o_prdata,
  output var  logic              o_pready,
  output var  logic              o_pslverr,
  // receive samples
  input  wire logic              i_smp_valid,
  input  wire logic [SMP_W-1:0]  i_rx_a,
  input  wire logic [SMP_W-1:0]  i_rx_b,
  input  wire logic [SYNC_N-1:0] i_sync_src,
  // delayed first path and interrupt
  output var  logic [SMP_W-1:0]  o_path_a,
  output var  logic              o_path_a_valid,
  output var  logic              o_irq
);
  logic [15:0]      sync_ctrl_q, len_low_q, per_low_q, start_dly_q, cfg_high_q;
  logic [ST_W-1:0]  irq_st_q, irq_mask_q;
  logic             cplx_q;
  logic [ACC_W-1:0] acc_q, result_q;
  logic [CNT_W-1:0] win_cnt_q, per_cnt_q;
  logic [DLY_W-1:0] dly_cnt_q;
  logic [DL_AW-1:0] wp_q, path_off_q;
  logic             rd_vld_q;
  meter_state_e     state_q;
  logic             sync_pulse, dl_pulse, en, acc_wr, hit;
  logic [5:0]       idx;
  logic [31:0]      rd_word;
  logic [CNT_W-1:0] len_end, per_end;
  logic [DLY_W-1:0] dly_end;
  logic             run_smp, start_evt, pub_evt;
  logic [32:0]      term;
  dl_mem_if         dl ();

  function automatic logic [31:0] sq(input logic signed [SMP_W-1:0] x);
    sq = 32'(x * x);
  endfunction : sq

  function automatic logic [CNT_W-1:0] span8(input logic [20:0] n);
    span8 = {1'b0, n, 3'b000} + WIN_EXTRA;
  endfunction : span8

  // apb: one wait state so that read data come from a flop
  assign idx    = i_paddr[7:2];
  assign acc_wr = i_psel & i_penable & o_pready & i_pwrite;
  assign en     = sync_ctrl_q[EN_A_BIT];

  always_comb
  begin
    rd_word = '0;
    hit     = 1'b1;
    unique case (idx)
      IDX_SYNC_CTRL:  rd_word = {16'h0000, sync_ctrl_q};
      IDX_LEN_LOW:    rd_word = {16'h0000, len_low_q};
      IDX_PER_LOW:    rd_word = {16'h0000, per_low_q};
      IDX_START_DLY:  rd_word = {16'h0000, start_dly_q};
      IDX_CFG_HIGH:   rd_word = {16'h0000, cfg_high_q};
      IDX_RESULT_LO:  rd_word = result_q[31:0];
      IDX_RESULT_HI:  rd_word = 32'(result_q[ACC_W-1:32]);
      IDX_IRQ_STATUS: rd_word = 32'(irq_st_q);
      IDX_IRQ_MASK:   rd_word = 32'(irq_mask_q);
      IDX_INPUT_MODE: rd_word = 32'(cplx_q);
      default:        hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end
    else if (i_psel && i_penable && !o_pready)
    begin
      o_pready  <= 1'b1;
      o_prdata  <= i_pwrite ? 32'h00000000 : rd_word;
      o_pslverr <= ~hit;
    end
    else
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      sync_ctrl_q <= REG_RESET;
      len_low_q   <= REG_RESET;
      per_low_q   <= REG_RESET;
      start_dly_q <= REG_RESET;
      cfg_high_q  <= REG_RESET;
      irq_mask_q  <= '0;
      cplx_q      <= 1'b0;
    end
    else if (acc_wr)
    begin
      unique case (idx)
        IDX_SYNC_CTRL: sync_ctrl_q <= i_pwdata[15:0];                   // R1
        IDX_LEN_LOW:   len_low_q   <= i_pwdata[15:0];                   // R3
        IDX_PER_LOW:   per_low_q   <= i_pwdata[15:0];                   // R7
        IDX_START_DLY: start_dly_q <= i_pwdata[15:0] & START_DLY_WMASK; // R10
        IDX_CFG_HIGH:  cfg_high_q  <= i_pwdata[15:0] & CFG_HIGH_WMASK;  // R12
        IDX_IRQ_MASK:  irq_mask_q  <= i_pwdata[ST_W-1:0];
        IDX_INPUT_MODE: cplx_q     <= i_pwdata[CPLX_BIT];               // R14
        default: ;
      endcase
    end
  end

  // sync sources for the meter and for the delay pointer
  sync_pick u_meter_sync (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_src     (i_sync_src),
    .i_sel     (sync_ctrl_q[SSEL_A_LSB +: SSEL_W]),
    .o_pulse   (sync_pulse)
  );

  sync_pick u_dl_sync (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_src     (i_sync_src),
    .i_sel     (cfg_high_q[DL_SSEL_LSB +: SSEL_W]),
    .o_pulse   (dl_pulse)
  );

  // window limits
  assign len_end = span8({cfg_high_q[LEN_HI_LSB +: HI_W], len_low_q}); // R3 R12
  assign per_end = span8({cfg_high_q[PER_HI_LSB +: HI_W], per_low_q}); // R7 R12
  assign dly_end = {1'b0, start_dly_q[START_LSB +: START_W], 3'b000} + START_EXTRA; // R10
  assign term    = {1'b0, sq(i_rx_a)} + (cplx_q ? {1'b0, sq(i_rx_b)} : 33'h000000000); // R4 R14

  assign run_smp   = i_smp_valid & en & ~sync_pulse & (state_q == ST_RUN);
  assign start_evt = i_smp_valid & en & ~sync_pulse
                   & (((state_q == ST_DELAY) & (dly_cnt_q == dly_end))     // R5
                   | ((state_q == ST_RUN) & (per_cnt_q == per_end)));     // R9
  assign pub_evt   = run_smp & (win_cnt_q == len_end);                   // R6

  // a new sync re-arms the delay even while a window runs
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      state_q   <= ST_IDLE;
      dly_cnt_q <= '0;
    end
    else if (!en)
    begin
      state_q <= ST_IDLE; // R1
    end
    else if (sync_pulse)
    begin
      state_q   <= ST_DELAY; // R5
      dly_cnt_q <= '0;
    end
    else if (i_smp_valid)
    begin
      unique case (state_q)
        ST_IDLE: ;
        ST_DELAY:
        begin
          if (dly_cnt_q == dly_end)
            state_q <= ST_RUN; // R10
          else
            dly_cnt_q <= dly_cnt_q + 1'b1;
        end
        ST_RUN: ;
      endcase
    end
  end

  // period counter counts samples since the window opened; window counter does too but holds at len_end+1
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      acc_q     <= '0;
      win_cnt_q <= '0;
      per_cnt_q <= '0;
    end
    else if (start_evt)
    begin
      acc_q     <= ACC_W'(term); // R9
      win_cnt_q <= 25'h0000001;
      per_cnt_q <= 25'h0000001;
    end
    else if (run_smp)
    begin
      per_cnt_q <= per_cnt_q + 1'b1; // R7
      if (win_cnt_q < len_end)
      begin
        acc_q     <= acc_q + ACC_W'(term); // R4
        win_cnt_q <= win_cnt_q + 1'b1;
      end
      else if (win_cnt_q == len_end)
        win_cnt_q <= win_cnt_q + 1'b1; // R15
    end
  end

  // result and interrupt; a set beats a clear in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      result_q <= '0;
      irq_st_q <= '0;
      o_irq    <= 1'b0;
    end
    else
    begin
      if (pub_evt)
        result_q <= acc_q; // R6 R15
      irq_st_q <= (irq_st_q & ~((acc_wr && idx == IDX_IRQ_STATUS) ?
                   i_pwdata[ST_W-1:0] : 2'b00))
                | {start_evt, pub_evt}; // R6
      o_irq    <= |(irq_st_q & irq_mask_q);
    end
  end

  // delay line: pointer offset taken on its own sync
  assign dl.we    = i_smp_valid;
  assign dl.waddr = wp_q;
  assign dl.wdata = i_rx_a;
  assign dl.raddr = wp_q - 6'h01 - path_off_q; // R11

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      wp_q           <= '0;
      path_off_q     <= '0;
      rd_vld_q       <= 1'b0;
      o_path_a       <= '0;
      o_path_a_valid <= 1'b0;
    end
    else
    begin
      if (i_smp_valid)
        wp_q <= wp_q + 1'b1;
      if (dl_pulse)
        path_off_q <= start_dly_q[PATH_OFF_LSB +: PATH_OFF_W]; // R13
      rd_vld_q       <= i_smp_valid;
      o_path_a_valid <= rd_vld_q;
      if (rd_vld_q)
        o_path_a <= dl.rdata;
    end
  end

  dl_mem u_dl_mem (
    .i_ref_clk (i_ref_clk),
    .m         (dl.mem)
  );

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_arm;
    en && sync_pulse;
  endsequence

  sequence s_delay_done;
    (state_q == ST_DELAY) && i_smp_valid && en && !sync_pulse
      && (dly_cnt_q == {1'b0, start_dly_q[8:0], 3'b000} + 13'h0002);
  endsequence

  off_idle_a: assert property (!en |=> state_q == ST_IDLE) // R1
    else $error("disabled meter left idle");

  arm_delay_a: assert property (s_arm |=> state_q == ST_DELAY && dly_cnt_q == 0) // R5
    else $error("sync did not arm the start delay");

  start_run_a: assert property (s_delay_done |=> state_q == ST_RUN // R10
    && win_cnt_q == 1 && per_cnt_q == 1)
    else $error("window did not open after the start delay");

  win_len_a: assert property (pub_evt |-> win_cnt_q == // R3
    {1'b0, cfg_high_q[15:11], len_low_q, 3'b000} + 25'h0000001)
    else $error("publish at wrong window length");

  publish_a: assert property (pub_evt |=> result_q == $past(acc_q) // R6
    && irq_st_q[ST_DONE_BIT])
    else $error("result or done flag missing");

  hold_res_a: assert property (!pub_evt |=> $stable(result_q)) // R15
    else $error("result changed without a finished window");

  period_wrap_a: assert property (run_smp && per_cnt_q == per_end // R7
    |=> win_cnt_q == 1 && per_cnt_q == 1 && irq_st_q[ST_START_BIT])
    else $error("period boundary did not restart the sum");

  sum_real_a: assert property (run_smp && !start_evt && win_cnt_q < len_end // R4
    && !cplx_q |=> acc_q == $past(acc_q) + ACC_W'(sq($past(i_rx_a))))
    else $error("real mode sum wrong");

  sum_cplx_a: assert property (run_smp && !start_evt && win_cnt_q < len_end // R14
    && cplx_q |=> acc_q == $past(acc_q) + ACC_W'(sq($past(i_rx_a)))
    + ACC_W'(sq($past(i_rx_b))))
    else $error("complex mode sum wrong");

  path_off_a: assert property (dl_pulse |=> path_off_q == $past(start_dly_q[15:10])) // R13
    else $error("delay pointer offset not taken on its sync");

  irq_level_a: assert property ((|(irq_st_q & irq_mask_q)) |=> o_irq) // R6
    else $error("unmasked status did not raise interrupt");
endmodule : input_power_meter
`default_nettype wire

// [design/sync_pick.sv]
// synchronises the sync sources and turns the chosen one into a pulse
`timescale 1ns/1ps
`default_nettype none
module sync_pick
  import pm_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  // sources and choice
  input  wire logic [SYNC_N-1:0] i_src,
  input  wire logic [SSEL_W-1:0] i_sel,
  // rising edge of the chosen source
  output var  logic              o_pulse
);
  logic [SYNC_N-1:0] s1_q;
  logic [SYNC_N-1:0] s2_q;
  logic [SYNC_N-1:0] s3_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      o_pulse <= 1'b0;
    end
    else
    begin
      s1_q    <= i_src;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      o_pulse <= s2_q[i_sel] & ~s3_q[i_sel]; // R2
    end
  end

  pick_edge_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R2
    (s2_q[i_sel] && !s3_q[i_sel]) |=> o_pulse)
    else $error("chosen sync edge gave no pulse");
endmodule : sync_pick
`default_nettype wire

// [inc/dl_mem_if.sv]
// carrier between the meter and its delay line memory
`timescale 1ns/1ps
`default_nettype none
interface dl_mem_if;
  import pm_pkg::*;
  logic                we;
  logic [DL_AW-1:0]    waddr;
  logic [DL_AW-1:0]    raddr;
  logic [SMP_W-1:0]    wdata;
  logic [SMP_W-1:0]    rdata;
  modport ctrl (output we, waddr, raddr, wdata, input rdata);
  modport mem  (input we, waddr, raddr, wdata, output rdata);
endinterface : dl_mem_if
`default_nettype wire

// [inc/pm_pkg.sv]
// constants, field layout and types of the input power meter
package pm_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SYNC_CTRL  = 6'h07;
  localparam logic [5:0] IDX_LEN_LOW    = 6'h08;
  localparam logic [5:0] IDX_PER_LOW    = 6'h09;
  localparam logic [5:0] IDX_START_DLY  = 6'h0A;
  localparam logic [5:0] IDX_CFG_HIGH   = 6'h0B;
  localparam logic [5:0] IDX_RESULT_LO  = 6'h10;
  localparam logic [5:0] IDX_RESULT_HI  = 6'h11;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h12;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h13;
  localparam logic [5:0] IDX_INPUT_MODE = 6'h14;
  localparam logic [15:0] REG_RESET     = 16'h0000;
  // writable bits; the rest read as zero
  localparam logic [15:0] START_DLY_WMASK = 16'hFDFF;
  localparam logic [15:0] CFG_HIGH_WMASK  = 16'hFFC7;
  // field positions
  localparam int EN_A_BIT     = 15;
  localparam int SSEL_A_LSB   = 12;
  localparam int SSEL_W       = 3;
  localparam int START_LSB    = 0;
  localparam int START_W      = 9;
  localparam int PATH_OFF_LSB = 10;
  localparam int PATH_OFF_W   = 6;
  localparam int LEN_HI_LSB   = 11;
  localparam int PER_HI_LSB   = 6;
  localparam int HI_W         = 5;
  localparam int DL_SSEL_LSB  = 0;
  localparam int CPLX_BIT     = 0;
  // interrupt status layout
  localparam int ST_DONE_BIT  = 0;
  localparam int ST_START_BIT = 1;
  localparam int ST_W         = 2;
  // counts in samples
  localparam logic [24:0] WIN_EXTRA   = 25'h0000001;
  localparam logic [12:0] START_EXTRA = 13'h0002;
  localparam int CNT_W       = 25;
  localparam int DLY_W       = 13;
  localparam int SMP_W       = 16;
  localparam int SYNC_N      = 8;
  localparam int DL_AW       = 6;
  localparam int DL_DEPTH    = 64;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} meter_state_e;
endpackage : pm_pkg

// [sim/input_power_meter_tb.sv]
// self-checking bench of the input power meter
`timescale 1ns/1ps
`default_nettype none
module input_power_meter_tb;
  import pm_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, sv, pav;
  logic [15:0] ra, rb, path_a;
  logic [7:0]  sync_src;
  int          miscompares = 0, compares = 0, cycles = 0;
  logic [31:0] q, lo;
  logic        e;
  always #2.5 i_ref_clk = ~i_ref_clk;
  pm_src src (.i_ref_clk(i_ref_clk), .o_smp_valid(sv), .o_rx_a(ra), .o_rx_b(rb),
    .o_sync_src(sync_src));
  input_power_meter DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_smp_valid(sv),
    .i_rx_a(ra), .i_rx_b(rb), .i_sync_src(sync_src), .o_path_a(path_a),
    .o_path_a_valid(pav), .o_irq(irq));
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; the wait for pready is open-ended, only the bench limit cuts it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    pen <= 1'b1;
    do
      @(posedge i_ref_clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < n)
    begin
      @(posedge i_ref_clk);
      k++;
    end
  endtask : wait_irq
  task automatic test_regs();
    logic [7:0]  ad [5] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
    logic [15:0] wm [5] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, START_DLY_WMASK, CFG_HIGH_WMASK};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ad[i], 32'h0);
      chk(q, {16'h0000, REG_RESET});
      apb(1'b1, ad[i], 32'h0000FFFF);
      apb(1'b0, ad[i], 32'h0);
      chk(q[15:0], wm[i]);
      apb(1'b1, ad[i], 32'h0);
    end
    apb(1'b1, 8'hFC, 32'h0000FFFF);
    chk({e, q}, 33'h100000000);
    $display("test regs done");
  endtask : test_regs
  // window of 9 samples, period of 17 samples, start delay of 10 samples
  task automatic test_meas(input logic cplx, input logic [63:0] exp);
    apb(1'b1, 8'h50, {31'h0, cplx});
    apb(1'b1, 8'h20, 32'h1);
    apb(1'b1, 8'h24, 32'h2);
    apb(1'b1, 8'h28, 32'h1);
    apb(1'b1, 8'h4C, 32'h1);
    apb(1'b1, 8'h1C, 32'hD000);
    src.pulse(5);
    wait_irq(200);
    chk(irq, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    lo = q;
    apb(1'b0, 8'h44, 32'h0);
    chk({q[23:0], lo}, exp);
    apb(1'b0, 8'h48, 32'h0);
    chk(q[ST_DONE_BIT], 1'b1);
    apb(1'b1, 8'h48, 32'h3);
    repeat (2) @(posedge i_ref_clk);
    chk(irq, 1'b0);
    wait_irq(100);
    chk(irq, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, lo);
    chk(path_a, 16'hFFF0);
    apb(1'b1, 8'h1C, 32'h0);
    apb(1'b1, 8'h48, 32'h3);
    $display("test meas done");
  endtask : test_meas
  task automatic test_quiet(input logic [31:0] ctrl, input int s);
    apb(1'b1, 8'h1C, ctrl);
    src.pulse(s);
    repeat (120) @(posedge i_ref_clk);
    chk(irq, 1'b0);
    apb(1'b1, 8'h1C, 32'h0);
    $display("test quiet done");
  endtask : test_quiet
  // ramped samples: offset 3 waits for its own sync, then the path lags 3 strobes more
  task automatic test_dline();
    apb(1'b1, 8'h2C, 32'h1);
    apb(1'b1, 8'h28, 32'h0C00);
    src.ramp <= 1'b1;
    repeat (20) @(posedge i_ref_clk);
    do
      @(posedge i_ref_clk);
    while (pav !== 1'b1);
    chk(16'(ra - path_a), 16'h0002);
    src.pulse(1);
    repeat (20) @(posedge i_ref_clk);
    do
      @(posedge i_ref_clk);
    while (pav !== 1'b1);
    chk(16'(ra - path_a), 16'h0005);
    $display("test dline done");
  endtask : test_dline
  initial
  begin
    src.set(16'hFFF0, 16'h0003);
    repeat (2) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    test_regs();
    test_meas(1'b0, 64'h900);
    test_meas(1'b1, 64'h951);
    test_quiet(32'h5000, 5);
    test_quiet(32'hD000, 2);
    test_dline();
    close_out();
  end
endmodule : input_power_meter_tb
`default_nettype wire

// [sim/pm_src.sv]
// sample source and sync sources standing in front of the meter
`timescale 1ns/1ps
`default_nettype none
module pm_src
(
  // clock
  input  wire logic        i_ref_clk,
  // samples and sync
  output var  logic        o_smp_valid,
  output var  logic [15:0] o_rx_a,
  output var  logic [15:0] o_rx_b,
  output var  logic [7:0]  o_sync_src
);
  // initialisers run before any initial block, so set() from the bench wins
  logic [15:0] a_q  = 16'h0000;
  logic [15:0] b_q  = 16'h0000;
  logic        ramp = 1'b0;
  initial
  begin
    o_smp_valid = 1'b0;
    o_sync_src  = 8'h00;
  end
  // a sample every second cycle; between strobes the lines show garbage
  always @(posedge i_ref_clk)
    o_smp_valid <= ~o_smp_valid;
  // ramp mode steps the in-phase value once per strobe
  always @(posedge i_ref_clk)
    if (ramp && o_smp_valid)
      a_q <= a_q + 16'h0001;
  assign o_rx_a = o_smp_valid ? a_q : ~a_q;
  assign o_rx_b = o_smp_valid ? b_q : ~b_q;
  task automatic set(input logic [15:0] a, input logic [15:0] b);
    a_q = a;
    b_q = b;
  endtask : set
  // held several cycles so the two-flop synchroniser sees it
  task automatic pulse(input int idx);
    @(posedge i_ref_clk);
    o_sync_src[idx] <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    o_sync_src[idx] <= 1'b0;
  endtask : pulse
endmodule : pm_src
`default_nettype wire
